// ---- hw/opt_top.sv ----
// Reference oscillator power telecommand decoder and control word.
// Assumes telecommand bytes, mode flags and restart share clk_i.
`timescale 1ns/1ns
`include "opt_cfg.svh"
module opt_top #(
  parameter int PKT_BYTES = `OPT_PKT_BYTES,
  parameter int CW_BITS   = `OPT_CW_BITS
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               tc_valid_i,
  input  wire logic               tc_sof_i,
  input  wire logic               tc_eof_i,
  input  wire logic [7:0]         tc_byte_i,
  input  wire logic               spec_mode_a_i,
  input  wire logic               spec_mode_b_i,
  input  wire logic               restart_i,
  input  wire logic               cw_wr_i,
  input  wire logic [CW_BITS-1:0] cw_wdata_i,
  output logic                    tc_acc_o,
  output logic                    tc_rej_o,
  output logic      [CW_BITS-1:0] ctrl_word_o,
  output logic      [CW_BITS-1:0] tlm_word_o,
  output logic                    ref_osc_pwr_o,
  output logic                    ser_clk_o,
  output logic                    ser_data_o,
  output logic                    ser_load_o
);

  localparam int BW = $clog2(CW_BITS);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PKT_BYTES != `OPT_PKT_BYTES || PKT_BYTES > 15) begin : g_pkt_chk
    $error("opt_top: packet length must be fourteen bytes");
  end
  if (CW_BITS <= `OPT_OSC_BIT) begin : g_cw_chk
    $error("opt_top: control word too narrow");
  end

  // ----------------------------------------------------------------
  // Receive image and byte count
  // ----------------------------------------------------------------
  opt_pkg::opt_tc_t tc_r;
  opt_pkg::opt_tc_t tc_nxt;
  logic [3:0]       cnt_r;
  logic [3:0]       cnt_nxt;
  logic             chk_r;
  logic             chk_nxt;
  logic [15:0]      crc;

  always_comb begin
    tc_nxt  = tc_r;
    cnt_nxt = cnt_r;
    chk_nxt = 1'b0;
    if (tc_valid_i) begin
      tc_nxt  = {tc_r[$bits(opt_pkg::opt_tc_t)-9:0], tc_byte_i};
      cnt_nxt = tc_sof_i ? 4'h1 : ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1);
      chk_nxt = tc_eof_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tc_r  <= '0;
      cnt_r <= 4'h0;
      chk_r <= 1'b0;
    end else begin
      tc_r  <= tc_nxt;
      cnt_r <= cnt_nxt;
      chk_r <= chk_nxt;
    end
  end

  opt_crc u_crc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .valid_i (tc_valid_i),
    .first_i (tc_sof_i),
    .byte_i  (tc_byte_i),
    .crc_o   (crc)
  );

  // ----------------------------------------------------------------
  // Packet checks
  // ----------------------------------------------------------------
  logic hdr_ok;
  logic id_ok;
  logic len_ok;
  logic pus_ok;
  logic ack_ok;
  logic type_ok;
  logic sub_ok;
  logic data_ok;
  logic pec_ok;
  logic cmd_ok;

  always_comb begin
    // R15 fixed constants
    hdr_ok  = tc_r.ver == `OPT_VER && tc_r.pkt_type && tc_r.dfh &&
              tc_r.seqf == `OPT_SEQF && tc_r.pad == `OPT_PAD;
    // R1 identity match
    id_ok   = tc_r.apid == `OPT_APID && tc_r.cat == `OPT_CAT;
    // R4 length and count
    len_ok  = tc_r.len == `OPT_LEN && cnt_r == 4'(PKT_BYTES);
    // R5 version and flag
    pus_ok  = tc_r.pus == `OPT_PUS && tc_r.chkf;
    // R6 acknowledge code
    ack_ok  = tc_r.ack == `OPT_ACK;
    // R7 private type
    type_ok = tc_r.ptype == `OPT_TYPE;
    // R8 oscillator subtype
    sub_ok  = tc_r.sub == `OPT_SUB;
    // R9 on or off only
    data_ok = tc_r.data[15:1] == 15'h0000;
    // R16 checksum residue
    pec_ok  = crc == `OPT_CRC_GOOD;
    cmd_ok  = chk_r && hdr_ok && id_ok && len_ok && pus_ok && ack_ok &&
              type_ok && sub_ok && data_ok && pec_ok;
  end

  // ----------------------------------------------------------------
  // Control word, telemetry and power
  // ----------------------------------------------------------------
  logic [CW_BITS-1:0] cw_r;
  logic [CW_BITS-1:0] cw_nxt;
  logic [CW_BITS-1:0] tlm_r;
  logic [CW_BITS-1:0] tlm_nxt;
  logic               pwr_r;
  logic               pwr_nxt;
  logic               acc_r;
  logic               rej_r;

  always_comb begin
    cw_nxt = cw_r;
    if (cw_wr_i) begin
      cw_nxt                = cw_wdata_i;
      cw_nxt[`OPT_OSC_BIT]  = cw_r[`OPT_OSC_BIT];
    end
    // R11 write oscillator bit
    if (cmd_ok) begin
      cw_nxt[`OPT_OSC_BIT] = tc_r.data[0];
    end
    // R13 restart clears
    if (restart_i) begin
      cw_nxt[`OPT_OSC_BIT] = 1'b0;
    end
    // R12 telemetry mirror
    tlm_nxt               = '0;
    tlm_nxt[`OPT_TLM_BIT] = cw_nxt[`OPT_OSC_BIT];
    // R14 spectroscopic modes
    pwr_nxt = cw_nxt[`OPT_OSC_BIT] | spec_mode_a_i | spec_mode_b_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cw_r  <= CW_BITS'(`OPT_CW_RST);
      tlm_r <= '0;
      pwr_r <= 1'b0;
      acc_r <= 1'b0;
      rej_r <= 1'b0;
    end else begin
      cw_r  <= cw_nxt;
      tlm_r <= tlm_nxt;
      pwr_r <= pwr_nxt;
      acc_r <= cmd_ok;
      rej_r <= chk_r && !cmd_ok;
    end
  end

  // ----------------------------------------------------------------
  // Serial shift of the control word to hardware
  // ----------------------------------------------------------------
  opt_pkg::opt_sh_t   st_r;
  opt_pkg::opt_sh_t   st_nxt;
  logic [CW_BITS-1:0] sh_r;
  logic [CW_BITS-1:0] sh_nxt;
  logic [BW-1:0]      bit_r;
  logic [BW-1:0]      bit_nxt;
  logic               pend_r;
  logic               pend_nxt;
  logic               sclk_r;
  logic               sdat_r;
  logic               sld_r;
  logic               start;

  always_comb begin
    st_nxt  = st_r;
    sh_nxt  = sh_r;
    bit_nxt = bit_r;
    start   = 1'b0;
    unique case (st_r)
      opt_pkg::OPT_SH_IDLE: begin
        if (pend_r) begin
          start   = 1'b1;
          sh_nxt  = cw_r;
          bit_nxt = BW'(CW_BITS - 1);
          st_nxt  = opt_pkg::OPT_SH_LOW;
        end
      end
      opt_pkg::OPT_SH_LOW: begin
        st_nxt = opt_pkg::OPT_SH_HIGH;
      end
      opt_pkg::OPT_SH_HIGH: begin
        if (bit_r == '0) begin
          st_nxt = opt_pkg::OPT_SH_LOAD;
        end else begin
          sh_nxt  = {sh_r[CW_BITS-2:0], 1'b0};
          bit_nxt = bit_r - 1'b1;
          st_nxt  = opt_pkg::OPT_SH_LOW;
        end
      end
      opt_pkg::OPT_SH_LOAD: begin
        st_nxt = opt_pkg::OPT_SH_IDLE;
      end
    endcase
    // R10 request shift out
    pend_nxt = (pend_r && !start) || cmd_ok || cw_wr_i || restart_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r   <= opt_pkg::OPT_SH_IDLE;
      sh_r   <= '0;
      bit_r  <= '0;
      pend_r <= 1'b0;
      sclk_r <= 1'b0;
      sdat_r <= 1'b0;
      sld_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      sh_r   <= sh_nxt;
      bit_r  <= bit_nxt;
      pend_r <= pend_nxt;
      sclk_r <= st_nxt == opt_pkg::OPT_SH_HIGH;
      sdat_r <= (st_nxt == opt_pkg::OPT_SH_IDLE) ? 1'b0 : sh_nxt[CW_BITS-1];
      sld_r  <= st_nxt == opt_pkg::OPT_SH_LOAD;
    end
  end

  assign tc_acc_o      = acc_r;
  assign tc_rej_o      = rej_r;
  assign ctrl_word_o   = cw_r;
  assign tlm_word_o    = tlm_r;
  assign ref_osc_pwr_o = pwr_r;
  assign ser_clk_o     = sclk_r;
  assign ser_data_o    = sdat_r;
  assign ser_load_o    = sld_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_accept;
    cmd_ok && !restart_i;
  endsequence

  sequence s_shift_start;
    ##[1:40] (st_r == opt_pkg::OPT_SH_LOW && bit_r == BW'(CW_BITS - 1));
  endsequence

  AST_ID_MATCH: assert property ( // R1
    (chk_r && !id_ok) |=> !tc_acc_o && tc_rej_o)
    else $error("accepted a foreign identifier or category");

  AST_LEN_SEVEN: assert property ( // R4
    (chk_r && tc_r.len != `OPT_LEN) |=> !tc_acc_o)
    else $error("accepted a packet with wrong length");

  AST_PUS_ZERO: assert property ( // R5
    (chk_r && !pus_ok) |=> !tc_acc_o)
    else $error("accepted a bad service version or flag");

  AST_ACK_CODE: assert property ( // R6
    (chk_r && tc_r.ack != `OPT_ACK) |=> !tc_acc_o)
    else $error("accepted a wrong acknowledge code");

  AST_TYPE_192: assert property ( // R7
    (chk_r && tc_r.ptype != `OPT_TYPE) |=> !tc_acc_o)
    else $error("accepted a wrong packet type");

  AST_SUB_11: assert property ( // R8
    (chk_r && tc_r.sub != `OPT_SUB) |=> $stable(ctrl_word_o[`OPT_OSC_BIT])
      || $past(restart_i) || $past(cw_wr_i))
    else $error("other subtype moved the oscillator bit");

  AST_DATA_RANGE: assert property ( // R9
    (chk_r && tc_r.data[15:1] != 15'h0000) |=> !tc_acc_o)
    else $error("accepted an undefined data value");

  AST_SHIFT_OUT: assert property ( // R10
    s_accept |=> s_shift_start)
    else $error("accepted setting not shifted out");

  AST_BIT_WRITE: assert property ( // R11
    s_accept |=> tc_acc_o && ctrl_word_o[`OPT_OSC_BIT] == $past(tc_r.data[0]))
    else $error("control bit does not hold commanded value");

  AST_TLM_MIRROR: assert property ( // R12
    tlm_word_o[`OPT_TLM_BIT] == ctrl_word_o[`OPT_OSC_BIT])
    else $error("telemetry bit differs from control bit");

  AST_RESTART_OFF: assert property ( // R13
    restart_i |=> !ctrl_word_o[`OPT_OSC_BIT] && !tlm_word_o[`OPT_TLM_BIT])
    else $error("restart did not clear the oscillator bit");

  AST_MODE_POWER: assert property ( // R14
    (spec_mode_a_i || spec_mode_b_i) |=> ref_osc_pwr_o)
    else $error("spectroscopic mode left oscillator off");

  AST_HDR_DISCARD: assert property ( // R15
    (chk_r && !hdr_ok) |=> tc_rej_o && !tc_acc_o)
    else $error("bad fixed header not discarded");

  AST_PEC_DISCARD: assert property ( // R16
    (chk_r && !pec_ok) |=> tc_rej_o && !tc_acc_o)
    else $error("bad checksum not discarded");

endmodule : opt_top

// ---- hw/opt_cfg.svh ----
// Constants of the reference oscillator power telecommand decoder.
// Assumes one 100 MHz clock and byte-serial telecommand delivery.
// Contract
// R1: Accept only packets with identifier 1000111 and category 1100.
// R2: Sender puts 000 in the upper three sequence count bits.
// R3: Sender keeps an 11-bit per-identifier counter from zero.
// R4: Length field must be seven; other lengths are not this command.
// R5: Service version 000 followed by checksum flag set to one.
// R6: Acknowledge field must be 0001, acceptance acknowledgement.
// R7: Packet type field must be 192.
// R8: Subtype 11 decodes as oscillator power command.
// R9: Data word 0 means off, 1 means on; nothing else valid.
// R10: On acceptance shift the new setting out to hardware at once.
// R11: Commanded value goes to control word bit 13, others untouched.
// R12: Telemetry control word shows oscillator bit at bit 10.
// R13: Power-on or software restart clears the oscillator bit.
// R14: Either spectroscopic mode powers the oscillator automatically.
// R15: Wrong fixed header constants discard the packet, no action.
// R16: Trailing checksum must match, else the packet is discarded.
`ifndef OPT_CFG_SVH
`define OPT_CFG_SVH

`define OPT_PKT_BYTES 14
`define OPT_CW_BITS   16
`define OPT_VER       3'h0
`define OPT_APID      7'h47
`define OPT_CAT       4'hc
`define OPT_SEQF      2'h3
`define OPT_LEN       16'h0007
`define OPT_PUS       3'h0
`define OPT_ACK       4'h1
`define OPT_TYPE      8'hc0
`define OPT_SUB       8'h0b
`define OPT_PAD       8'h00
`define OPT_OSC_BIT   13
`define OPT_TLM_BIT   10
`define OPT_CW_RST    16'h0000
`define OPT_CRC_INIT  16'hffff
`define OPT_CRC_POLY  16'h1021
`define OPT_CRC_GOOD  16'h0000

`endif

// ---- hw/opt_pkg.sv ----
// Types of the reference oscillator power telecommand decoder.
// Assumes the constants header is compiled alongside.
package opt_pkg;

  // ----------------------------------------------------------------
  // Telecommand image, first byte in the top bits
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  ver;
    logic        pkt_type;
    logic        dfh;
    logic [6:0]  apid;
    logic [3:0]  cat;
    logic [1:0]  seqf;
    logic [13:0] seqc;
    logic [15:0] len;
    logic [2:0]  pus;
    logic        chkf;
    logic [3:0]  ack;
    logic [7:0]  ptype;
    logic [7:0]  sub;
    logic [7:0]  pad;
    logic [15:0] data;
    logic [15:0] pec;
  } opt_tc_t;

  // ----------------------------------------------------------------
  // Serial control word shifter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPT_SH_IDLE = 2'b00,
    OPT_SH_LOW  = 2'b01,
    OPT_SH_HIGH = 2'b10,
    OPT_SH_LOAD = 2'b11
  } opt_sh_t;

endpackage : opt_pkg

// ---- hw/opt_crc.sv ----
// Running packet checksum over the telecommand byte stream.
// Assumes bytes arrive on the same clock with a first-byte marker.
`timescale 1ns/1ns
`include "opt_cfg.svh"
module opt_crc (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        valid_i,
  input  wire logic        first_i,
  input  wire logic [7:0]  byte_i,
  output logic      [15:0] crc_o
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ({x[14:0], 1'b0} ^ `OPT_CRC_POLY) : {x[14:0], 1'b0};
    end
    return x;
  endfunction : crc_step

  // ----------------------------------------------------------------
  // Checksum register
  // ----------------------------------------------------------------
  always_comb begin
    crc_nxt = crc_r;
    if (valid_i) begin
      crc_nxt = crc_step(first_i ? `OPT_CRC_INIT : crc_r, byte_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crc_r <= `OPT_CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = crc_r;

endmodule : opt_crc

// ---- testbench/opt_src.sv ----
// Ground telecommand source model, one byte per strobe.
// Assumes each send starts just after a rising edge of clk_i.
`timescale 1ns/1ns
`include "opt_cfg.svh"
module opt_src (
  input  wire logic       clk_i,
  output logic            tc_valid_o,
  output logic            tc_sof_o,
  output logic            tc_eof_o,
  output logic [7:0]      tc_byte_o
);
  // --------------------------------------------------------------
  // Packet builder
  // --------------------------------------------------------------
  logic [10:0] seq_cnt;
  initial begin
    seq_cnt = 11'h000;
    tc_valid_o = 1'b0;
    tc_sof_o = 1'b0;
    tc_eof_o = 1'b0;
    tc_byte_o = 8'h00;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `OPT_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_step
  task automatic send(input logic [15:0] data, input int fault);
    opt_pkg::opt_tc_t pk;
    logic [15:0]      crc;
    int               n;
    pk = '{ver:3'h0, pkt_type:1'b1, dfh:1'b1, apid:7'h47, cat:4'hc,
      seqf:2'h3, seqc:{3'h0, seq_cnt}, len:16'h0007, pus:3'h0,
      chkf:1'b1, ack:4'h1, ptype:8'hc0, sub:8'h0b, pad:8'h00,
      data:data, pec:16'h0000};
    seq_cnt = seq_cnt + 11'h001;
    case (fault)
      1: pk.apid = 7'h46;
      2: pk.cat = 4'hd;
      3: pk.len = 16'h0008;
      4: pk.ptype = 8'hc1;
      5: pk.sub = 8'h65;
      6: pk.ack = 4'h2;
      7: pk.pus = 3'h1;
      8: pk.pad = 8'h01;
      9: pk.ver = 3'h1;
      10: pk.seqf = 2'h1;
      11: pk.chkf = 1'b0;
      14: pk.pkt_type = 1'b0;
      15: pk.dfh = 1'b0;
      default: ;
    endcase
    crc = `OPT_CRC_INIT;
    for (int i = 0; i < 12; i++) begin
      crc = crc_step(crc, pk[111-8*i -: 8]);
    end
    pk.pec = (fault == 12) ? ~crc : crc;
    n = (fault == 13) ? 13 : 14;
    for (int i = 0; i < n; i++) begin
      tc_valid_o = 1'b1;
      tc_sof_o = (i == 0);
      tc_eof_o = (i == n - 1);
      tc_byte_o = pk[111-8*i -: 8];
      @(posedge clk_i);
      #1;
    end
  endtask : send
  task automatic idle;
    tc_valid_o = 1'b0;
    tc_sof_o = 1'b0;
    tc_eof_o = 1'b0;
    tc_byte_o = ~tc_byte_o;
  endtask : idle
endmodule : opt_src

// ---- testbench/opt_top_bench.sv ----
// Self-checking bench of the oscillator telecommand decoder.
// Assumes the source model drives the byte stream inputs.
`timescale 1ns/1ns
module opt_top_bench;
  // --------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------
  typedef struct {
    logic [15:0] data;
    int          fault;
    logic        acc;
  } opt_row_t;
  logic        clk, rst_n, spec_a, spec_b, restart, cw_wr;
  logic        tc_valid, tc_sof, tc_eof, tc_acc, tc_rej;
  logic        ref_osc, ser_clk, ser_data, ser_load, a, r, ld;
  logic [7:0]  tc_byte;
  logic [15:0] cw_wdata, ctrl, tlm, exp_cw, w;
  int          fail_count, n_tests, na, nr;
  opt_row_t    rows [19] = '{'{16'h1, 0, 1}, '{16'h0, 1, 0},
    '{16'h0, 2, 0}, '{16'h0, 3, 0}, '{16'h0, 4, 0}, '{16'h0, 5, 0},
    '{16'h0, 6, 0}, '{16'h0, 7, 0}, '{16'h0, 8, 0}, '{16'h0, 9, 0},
    '{16'h0, 10, 0}, '{16'h0, 11, 0}, '{16'h0, 12, 0},
    '{16'h0, 13, 0}, '{16'h0, 14, 0}, '{16'h0, 15, 0},
    '{16'h2, 0, 0}, '{16'h0, 0, 1}, '{16'h1, 0, 1}};
  opt_src u_opt_src (.clk_i(clk), .tc_valid_o(tc_valid),
    .tc_sof_o(tc_sof), .tc_eof_o(tc_eof), .tc_byte_o(tc_byte));
  opt_top u_opt_top (.clk_i(clk), .rst_n_i(rst_n),
    .tc_valid_i(tc_valid), .tc_sof_i(tc_sof), .tc_eof_i(tc_eof),
    .tc_byte_i(tc_byte), .spec_mode_a_i(spec_a),
    .spec_mode_b_i(spec_b), .restart_i(restart), .cw_wr_i(cw_wr),
    .cw_wdata_i(cw_wdata), .tc_acc_o(tc_acc), .tc_rej_o(tc_rej),
    .ctrl_word_o(ctrl), .tlm_word_o(tlm), .ref_osc_pwr_o(ref_osc),
    .ser_clk_o(ser_clk), .ser_data_o(ser_data),
    .ser_load_o(ser_load));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------------------------------------
  // Helper tasks
  // --------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp,
                         input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [15:0] got,
                          input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word
  task automatic check_state;
    chk_word(ctrl, exp_cw, "control word");
    chk_word(tlm, {5'h00, exp_cw[13], 10'h000}, "telemetry");
  endtask : check_state
  task automatic wait_res;
    a = 1'b0;
    r = 1'b0;
    for (int i = 0; i < 6 && !(a || r); i++) begin
      @(posedge clk);
      #1;
      a = tc_acc;
      r = tc_rej;
    end
  endtask : wait_res
  task automatic cap_shift;
    logic prev;
    prev = 1'b0;
    w = 16'h0000;
    ld = 1'b0;
    for (int i = 0; i < 60 && !ld; i++) begin
      @(posedge clk);
      #1;
      if (ser_clk && !prev) w = {w[14:0], ser_data};
      prev = ser_clk;
      ld = ser_load;
    end
    chk_bit(ld, 1'b1, "load pulse");
    chk_word(w, exp_cw, "shifted word");
  endtask : cap_shift
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, spec_a, spec_b, restart, cw_wr} = 5'h00;
    cw_wdata = 16'h0000;
    exp_cw = 16'h0000;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check_state();
    chk_bit(ref_osc, 1'b0, "power after reset");
    $display("test reset done");
    foreach (rows[k]) begin
      u_opt_src.send(rows[k].data, rows[k].fault);
      u_opt_src.idle();
      wait_res();
      chk_bit(a, rows[k].acc, "accept");
      chk_bit(r, !rows[k].acc, "reject");
      if (rows[k].acc) exp_cw[13] = rows[k].data[0];
      check_state();
      repeat (40) @(posedge clk);
      #1;
    end
    $display("test table done");
    cw_wdata = 16'h5555;
    cw_wr = 1'b1;
    @(posedge clk);
    #1 cw_wr = 1'b0;
    exp_cw = 16'h7555;
    cap_shift();
    check_state();
    u_opt_src.send(16'h0000, 0);
    u_opt_src.idle();
    exp_cw = 16'h5555;
    wait_res();
    cap_shift();
    check_state();
    $display("test shift done");
    for (int m = 0; m < 4; m++) begin
      {spec_b, spec_a} = m[1:0];
      repeat (2) @(posedge clk);
      #1 chk_bit(ref_osc, m != 0, "mode power");
      check_state();
    end
    {spec_b, spec_a} = 2'b00;
    $display("test modes done");
    na = 0;
    nr = 0;
    fork
      begin
        u_opt_src.send(16'h0000, 12);
        u_opt_src.send(16'h0001, 0);
        u_opt_src.idle();
      end
      repeat (34) begin
        @(posedge clk);
        #1;
        na += tc_acc;
        nr += tc_rej;
      end
    join
    exp_cw[13] = 1'b1;
    chk_bit(na == 1 && nr == 1, 1'b1, "pulse count");
    check_state();
    chk_bit(ref_osc, 1'b1, "commanded power");
    $display("test back to back done");
    restart = 1'b1;
    @(posedge clk);
    #1 restart = 1'b0;
    exp_cw[13] = 1'b0;
    check_state();
    chk_bit(ref_osc, 1'b0, "power after restart");
    repeat (40) @(posedge clk);
    #1;
    $display("test restart done");
    u_opt_src.send(16'h0001, 0);
    u_opt_src.idle();
    wait_res();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    exp_cw = 16'h0000;
    check_state();
    chk_bit(ref_osc, 1'b0, "power after second reset");
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : opt_top_bench
